// >>> src/tca_pkg.sv
// shared constants, field layouts and types of the timer control-a block
package tca_pkg;
  // bus and register map
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  OFS_TIMER_CONTROL_A     = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_PER       = 8'h08;
  localparam logic [7:0]  OFS_CC0       = 8'h0c;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_CTRLB     = 8'h14;
  localparam logic [7:0]  OFS_DBG       = 8'h18;

  // control-a field positions
  localparam int          CA_SOFTWARE_RESET_BIT_BIT  = 0;
  localparam int          CA_ENABLE_BIT = 1;
  localparam int          CA_MODE_LSB   = 2;
  localparam int          CA_WAVE_LSB   = 5;
  localparam int          CA_DIV_LSB    = 8;
  localparam int          CA_STBY_BIT   = 11;
  localparam int          CA_ALIGN_LSB  = 12;
  localparam logic [15:0] TIMER_CONTROL_A_MASK    = 16'h3f6f;

  // status, control-b and debug bit positions
  localparam int          SB_SOFTWARE_RESET_BIT_BIT  = 0;
  localparam int          SB_ENABLE_BIT = 1;
  localparam int          ST_ACTIVE_BIT = 2;
  localparam int          CB_DOWN_BIT   = 0;
  localparam int          DBG_RUN_BIT   = 0;

  // reset values
  localparam logic [15:0] TIMER_CONTROL_A_RESET   = 16'h0000;
  localparam logic [7:0]  PER_RESET     = 8'h00;
  localparam logic [31:0] CC0_RESET     = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET   = 32'h0000_0000;

  // timing: enable and software reset synchronisation delay
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          SYNC_TIME_NS  = 100;
  localparam int          SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // divider: log2 of the division factor per select code
  localparam int          DIV_W         = 10;
  localparam int          DIV_SHIFT [8] = '{0, 1, 2, 3, 4, 6, 8, 10};

  typedef enum logic [1:0] {WIDTH_16, WIDTH_8, WIDTH_32, WIDTH_RSV} tca_width_e;
  typedef enum logic [1:0] {NORMAL_FREQ, MATCH_FREQ, NORMAL_PWM, MATCH_PWM} tca_wave_e;
  typedef enum logic [1:0] {NEXT_GENERIC, NEXT_TICK, DIVIDER_CLEAR, ALIGN_RSV} tca_align_e;

  typedef struct packed {
    logic [1:0] rsv15;
    tca_align_e align;
    logic       stby;
    logic [2:0] div;
    logic       rsv7;
    tca_wave_e  wave;
    logic       rsv4;
    tca_width_e width;
    logic       enable;
    logic       software_reset_bit;
  } tca_timer_control_a_s;
endpackage

// >>> src/tca_divider.sv
// clock divider producing one-cycle divided ticks from the generic clock enable
`timescale 1ns/1ps
module tca_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       next_generic_edge_option_en,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [tca_pkg::DIV_W-1:0] cnt_q;
  logic [tca_pkg::DIV_W-1:0] limit;

  always_comb begin
    limit = '0;
    for (int i = 0; i < 8; i++) begin
      if (sel == 3'(i)) begin
        limit = tca_pkg::DIV_W'((1 << tca_pkg::DIV_SHIFT[i]) - 1);
      end
    end
  end

  assign tick = next_generic_edge_option_en & run & ~clear & (cnt_q == limit);

  // cleared on disable, software reset or a divider_clear_option wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (next_generic_edge_option_en && run) begin
      cnt_q <= (cnt_q == limit) ? '0 : cnt_q + 1'b1;
    end
  end
endmodule // tca_divider

// >>> src/tca_top.sv
// timer control-a logic with apb register access, divider, counter and waveform output
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module tca_top #(
  parameter int SYNC_CYCLES = tca_pkg::SYNC_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [tca_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      next_generic_edge_option_en,
  input  wire logic                      standby_req,
  input  wire logic                      debug_halt,
  input  wire logic                      guard_wp,
  output logic                           wave_out,
  output logic                           timer_active
);
  localparam int CNT_W = $clog2(SYNC_CYCLES + 1);

  if (SYNC_CYCLES < 1 || SYNC_CYCLES > 255) begin : g_bad_sync
    $error("sync delay must be 1 to 255 cycles");
  end

  tca_pkg::tca_timer_control_a_s timer_control_a_q;
  logic [7:0]          per_q;
  logic [31:0]         cc0_q;
  logic [31:0]         count_q;
  logic                down_q;
  logic                dbg_run_q;
  logic                active_q;
  logic                en_busy_q;
  logic [CNT_W-1:0]    sync_cnt_q;
  logic                wrap_pend_q;
  logic                wave_q;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;

  logic        access_ph;
  logic        wr_commit;
  logic        wr_ok;
  logic        timer_control_a_wr;
  logic        software_reset_bit_req;
  logic        sync_fire;
  logic        software_reset_bit_done;
  logic        hit;
  logic        err_val;
  logic [31:0] rd_val;
  logic [15:0] timer_control_a_new;
  logic        run;
  logic        tick;
  logic        div_clear;
  logic [31:0] mask;
  logic [31:0] top;
  logic [31:0] cmp;
  logic        at_end;
  logic        wrap_apply;
  logic        match;
  logic        pwm_mode;

  // byte-lane merge; strobes let 8, 16 and 32-bit writes touch only their lanes
  function automatic logic [31:0] tca_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ---------------- apb slave: one wait state, registered answer
  assign access_ph = psel & penable;
  assign wr_commit = access_ph & pready_q & pwrite & ~pslverr_q;
  // every register write, a second reset request included, is ignored while a software reset is pending
  assign wr_ok     = wr_commit & ~timer_control_a_q.software_reset_bit;

  always_comb begin
    case (paddr)
      tca_pkg::OFS_TIMER_CONTROL_A, tca_pkg::OFS_STATUS, tca_pkg::OFS_PER, tca_pkg::OFS_CC0,
      tca_pkg::OFS_COUNT, tca_pkg::OFS_CTRLB, tca_pkg::OFS_DBG: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    err_val = ~hit;
    if (pwrite && paddr == tca_pkg::OFS_TIMER_CONTROL_A && guard_wp) begin
      err_val = 1'b1;
    end
    if (pwrite && (paddr == tca_pkg::OFS_STATUS || paddr == tca_pkg::OFS_COUNT)) begin
      err_val = 1'b1;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      tca_pkg::OFS_TIMER_CONTROL_A: rd_val = {16'h0000, 16'(timer_control_a_q)};
      tca_pkg::OFS_STATUS: begin
        rd_val[tca_pkg::SB_SOFTWARE_RESET_BIT_BIT]  = timer_control_a_q.software_reset_bit;
        rd_val[tca_pkg::SB_ENABLE_BIT] = en_busy_q;
        rd_val[tca_pkg::ST_ACTIVE_BIT] = active_q;
      end
      tca_pkg::OFS_PER:   rd_val = {24'h00_0000, per_q};
      tca_pkg::OFS_CC0:   rd_val = cc0_q;
      tca_pkg::OFS_COUNT: rd_val = count_q;
      tca_pkg::OFS_CTRLB: rd_val[tca_pkg::CB_DOWN_BIT] = down_q;
      tca_pkg::OFS_DBG:   rd_val[tca_pkg::DBG_RUN_BIT] = dbg_run_q;
      default:            rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= access_ph & ~pready_q;
      if (access_ph && !pready_q) begin
        pslverr_q <= err_val;
        prdata_q  <= (pwrite || err_val) ? 32'h0000_0000 : rd_val;
      end else begin
        // the error answer stands only in the cycle that carries ready
        pslverr_q <= 1'b0;
      end
    end
  end

  // ---------------- control-a and its synchronised bits
  assign timer_control_a_wr  = wr_ok & (paddr == tca_pkg::OFS_TIMER_CONTROL_A);
  assign software_reset_bit_req = timer_control_a_wr & pstrb[0] & pwdata[tca_pkg::CA_SOFTWARE_RESET_BIT_BIT];
  assign timer_control_a_new = 16'(tca_merge({16'h0000, 16'(timer_control_a_q)}, pwdata, pstrb))
                     & tca_pkg::TIMER_CONTROL_A_MASK;
  assign sync_fire  = (sync_cnt_q == CNT_W'(1));
  assign software_reset_bit_done = sync_fire & timer_control_a_q.software_reset_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_a_q <= tca_pkg::tca_timer_control_a_s'(tca_pkg::TIMER_CONTROL_A_RESET);
    end else if (software_reset_bit_done) begin
      timer_control_a_q <= tca_pkg::tca_timer_control_a_s'(tca_pkg::TIMER_CONTROL_A_RESET);
    end else if (software_reset_bit_req) begin
      timer_control_a_q.software_reset_bit <= 1'b1;
    end else if (timer_control_a_wr) begin
      if (!timer_control_a_q.enable && !active_q) begin
        // protected fields take the new value only while stopped
        timer_control_a_q <= tca_pkg::tca_timer_control_a_s'({timer_control_a_new[15:2], timer_control_a_q.enable, 1'b0});
      end
      if (pstrb[0]) begin
        timer_control_a_q.enable <= timer_control_a_new[tca_pkg::CA_ENABLE_BIT];
      end
    end
  end

  // shared delay counter for enable and reset synchronisation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cnt_q <= '0;
      en_busy_q  <= 1'b0;
      active_q   <= 1'b0;
    end else if (software_reset_bit_done) begin
      sync_cnt_q <= '0;
      en_busy_q  <= 1'b0;
      active_q   <= 1'b0;
    end else if (software_reset_bit_req) begin
      sync_cnt_q <= CNT_W'(SYNC_CYCLES);
      en_busy_q  <= 1'b0;
    end else if (timer_control_a_wr && pstrb[0]) begin
      sync_cnt_q <= CNT_W'(SYNC_CYCLES);
      en_busy_q  <= 1'b1;
    end else begin
      if (sync_cnt_q != '0) begin
        sync_cnt_q <= sync_cnt_q - 1'b1;
      end
      if (sync_fire && en_busy_q) begin
        active_q  <= timer_control_a_q.enable;
        en_busy_q <= 1'b0;
      end
    end
  end

  // ---------------- other timer registers; debug control survives software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_q  <= tca_pkg::PER_RESET;
      cc0_q  <= tca_pkg::CC0_RESET;
      down_q <= 1'b0;
    end else if (software_reset_bit_done) begin
      per_q  <= tca_pkg::PER_RESET;
      cc0_q  <= tca_pkg::CC0_RESET;
      down_q <= 1'b0;
    end else if (wr_ok) begin
      if (paddr == tca_pkg::OFS_PER) begin
        per_q <= 8'(tca_merge({24'h00_0000, per_q}, pwdata, pstrb));
      end
      if (paddr == tca_pkg::OFS_CC0) begin
        cc0_q <= tca_merge(cc0_q, pwdata, pstrb);
      end
      if (paddr == tca_pkg::OFS_CTRLB && pstrb[0]) begin
        down_q <= pwdata[tca_pkg::CB_DOWN_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_run_q <= 1'b0;
    end else if (wr_ok && paddr == tca_pkg::OFS_DBG && pstrb[0]) begin
      dbg_run_q <= pwdata[tca_pkg::DBG_RUN_BIT];
    end
  end

  // ---------------- counting path; fields are used as stored, divider_clear_option clears the divider on wrap
  assign run = active_q & ~(standby_req & ~timer_control_a_q.stby)
               & ~(debug_halt & ~dbg_run_q);

  assign div_clear = ~active_q | software_reset_bit_done
                     | (wrap_apply & (timer_control_a_q.align == tca_pkg::DIVIDER_CLEAR));

  tca_divider i_tca_divider (
    .clk     (pclk),
    .rst_n   (presetn),
    .next_generic_edge_option_en (next_generic_edge_option_en),
    .run     (run),
    .clear   (div_clear),
    .sel     (timer_control_a_q.div),
    .tick    (tick)
  );

  always_comb begin
    case (timer_control_a_q.width)
      tca_pkg::WIDTH_8:  mask = 32'h0000_00ff;
      tca_pkg::WIDTH_32: mask = 32'hffff_ffff;
      default:           mask = 32'h0000_ffff; // reserved code behaves as 16-bit
    endcase
  end

  assign cmp      = cc0_q & mask;
  assign pwm_mode = (timer_control_a_q.wave == tca_pkg::NORMAL_PWM) | (timer_control_a_q.wave == tca_pkg::MATCH_PWM);

  always_comb begin
    if (timer_control_a_q.wave == tca_pkg::MATCH_FREQ || timer_control_a_q.wave == tca_pkg::MATCH_PWM) begin
      top = cmp;
    end else if (timer_control_a_q.width == tca_pkg::WIDTH_8) begin
      top = {24'h00_0000, per_q};
    end else begin
      top = mask;
    end
  end

  assign at_end = down_q ? (count_q == 32'h0000_0000) : (count_q == top);
  assign match  = tick & ~wrap_pend_q & (count_q == cmp);

  // reload waits for the edge chosen by the alignment field
  assign wrap_apply = wrap_pend_q & run
                      & ((timer_control_a_q.align == tca_pkg::NEXT_TICK) ? tick : next_generic_edge_option_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q     <= tca_pkg::COUNT_RESET;
      wrap_pend_q <= 1'b0;
    end else if (software_reset_bit_done || !active_q) begin
      wrap_pend_q <= 1'b0;
      if (software_reset_bit_done) begin
        count_q <= tca_pkg::COUNT_RESET;
      end
    end else if (wrap_apply) begin
      count_q     <= down_q ? top : 32'h0000_0000;
      wrap_pend_q <= 1'b0;
    end else if (tick && !wrap_pend_q) begin
      if (at_end) begin
        wrap_pend_q <= 1'b1;
      end else if (down_q) begin
        count_q <= (count_q - 32'h0000_0001) & mask;
      end else begin
        count_q <= (count_q + 32'h0000_0001) & mask;
      end
    end
  end

  // wrap beats match so match-pwm at top still sets the output when counting up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_q <= 1'b0;
    end else if (software_reset_bit_done) begin
      wave_q <= 1'b0;
    end else if (wrap_apply && pwm_mode) begin
      wave_q <= ~down_q;
    end else if (match) begin
      wave_q <= pwm_mode ? down_q : ~wave_q;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign wave_out     = wave_q;
  assign timer_active = active_q;
endmodule // tca_top

// >>> tb/tca_assertions.sv
// concurrent checks on the apb side and enable timing of the timer control-a block
`timescale 1ns/1ps
module tca_assertions #(
  parameter int SYNC_CYCLES = tca_pkg::SYNC_CYCLES
) (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [tca_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       guard_wp,
  input wire logic                       timer_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ctl_wr;
  // committed control-a write that reaches the low byte
  assign ctl_wr = psel && penable && pready && pwrite && !pslverr
                  && paddr == tca_pkg::OFS_TIMER_CONTROL_A && pstrb[0];

  sequence s_first_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  AST_READY_NEXT: assert property (s_first_access |=> s_answer)
    else $error("ready not one cycle after the first access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error answer without ready");
  AST_GUARD_REFUSED: assert property ((s_first_access ##0 (pwrite && guard_wp
    && paddr == tca_pkg::OFS_TIMER_CONTROL_A)) |=> pready && pslverr)
    else $error("protected control write not refused");
  AST_STATUS_RO: assert property ((s_first_access ##0 (pwrite
    && paddr == tca_pkg::OFS_STATUS)) |=> pslverr)
    else $error("status write not refused");
  AST_UNMAPPED: assert property ((s_first_access ##0 (paddr[1:0] != 2'b00
    || paddr > tca_pkg::OFS_DBG)) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_EN_DELAY: assert property ($rose(timer_active)
    |-> $past(ctl_wr && pwdata[1] && !pwdata[0], SYNC_CYCLES + 1))
    else $error("timer started without an enable write one delay earlier");
  AST_DIS_DELAY: assert property ($fell(timer_active)
    |-> $past(ctl_wr && (!pwdata[1] || pwdata[0]), SYNC_CYCLES + 1))
    else $error("timer stopped without a disable or reset write one delay earlier");
endmodule // tca_assertions

bind tca_top tca_assertions #(.SYNC_CYCLES(SYNC_CYCLES)) i_tca_assertions (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .pready, .pslverr, .guard_wp, .timer_active);

// >>> tb/timer_control_a_logic_bench.sv
// self-checking bench for the timer control-a block
`timescale 1ns/1ps
module timer_control_a_logic_bench;
  // long enough that the busy bits can still be read back before they clear
  localparam int SYNC = 16;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] x;
    logic        we;
    logic        re;
  } tca_row_s;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        next_generic_edge_option_en = 1'b0;
  logic        standby_req = 1'b0;
  logic        debug_halt = 1'b0;
  logic        guard_wp = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] cnt;
  logic        pready;
  logic        pslverr;
  logic        wave_out;
  logic        timer_active;
  logic        er;
  int          miscompares = 0;
  int          tests_run = 0;
  int          hi;
  tca_row_s    rows [10] = '{
    '{8'h00, 32'h2b68, 4'hf, 32'h2b68, 1'b0, 1'b0},
    '{8'h00, 32'h1424, 4'hf, 32'h1424, 1'b0, 1'b0},
    '{8'h00, 32'h0700, 4'h2, 32'h0724, 1'b0, 1'b0},
    '{8'h00, 32'hff48, 4'h1, 32'h0748, 1'b0, 1'b0},
    '{8'h00, 32'h0000, 4'h3, 32'h0000, 1'b0, 1'b0},
    '{8'h1c, 32'h1111, 4'hf, 32'h0000, 1'b1, 1'b1},
    '{8'h02, 32'h2222, 4'hf, 32'h0000, 1'b1, 1'b1},
    '{8'h04, 32'h0007, 4'hf, 32'h0000, 1'b1, 1'b0},
    '{8'h08, 32'hffab, 4'h1, 32'h00ab, 1'b0, 1'b0},
    '{8'h18, 32'h0001, 4'hf, 32'h0001, 1'b0, 1'b0}};

  tca_top #(.SYNC_CYCLES(SYNC)) i_tca_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .next_generic_edge_option_en, .standby_req, .debug_halt, .guard_wp, .wave_out,
    .timer_active);

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? s : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts the cycles in which the waveform output is high
  task automatic hcount(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge pclk);
      if (wave_out === 1'b1) begin
        h++;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, x);
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  end

  initial begin
    repeat (5) @(posedge pclk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
      chk({31'h0, er}, {31'h0, rows[i].we});
      rdc(rows[i].a, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].re});
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 8'h00, 32'(c) << 8, 4'h3);
      rdc(8'h00, 32'(c) << 8);
    end
    apb(1'b1, 8'h00, 32'h0202, 4'h3);
    rdc(8'h00, 32'h0202);
    rdc(8'h04, 32'h0002);
    for (int n = 0; n < 20 && timer_active !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, timer_active}, 32'h1);
    rdc(8'h04, 32'h0004);
    apb(1'b1, 8'h00, 32'h0702, 4'h3);
    rdc(8'h00, 32'h0202);
    // divide by four: 64 generic edges give 16 ticks, one may still be in flight
    next_generic_edge_option_en <= 1'b1;
    repeat (64) @(posedge pclk);
    next_generic_edge_option_en <= 1'b0;
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    cnt = rd;
    tests_run++;
    if (rd !== 32'd15 && rd !== 32'd16) begin
      miscompares++;
      $display("unexpected at %0t: count %h after 64 edges", $time, rd);
    end
    standby_req <= 1'b1;
    next_generic_edge_option_en <= 1'b1;
    repeat (16) @(posedge pclk);
    next_generic_edge_option_en <= 1'b0;
    standby_req <= 1'b0;
    rdc(8'h10, cnt);
    guard_wp <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000, 4'h3);
    guard_wp <= 1'b0;
    chk({31'h0, er}, 32'h1);
    rdc(8'h00, 32'h0202);
    apb(1'b1, 8'h00, 32'h0f03, 4'h3);
    apb(1'b0, 8'h00, 32'h0, 4'h0);
    chk(rd & 32'h0f01, 32'h0201);
    rdc(8'h04, 32'h0005);
    for (int n = 0; n < 10 && rd[0] !== 1'b0; n++) apb(1'b0, 8'h04, 32'h0, 4'h0);
    chk(rd, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h18, 32'h1);
    chk({30'h0, timer_active, wave_out}, 32'h0);
    // 8-bit pwm with top 3 and compare 1: five-edge period, high for two of them
    apb(1'b1, 8'h08, 32'h0000_0003, 4'h1);
    apb(1'b1, 8'h0c, 32'h0000_0001, 4'hf);
    apb(1'b1, 8'h00, 32'h0000_0046, 4'h3);
    next_generic_edge_option_en <= 1'b1;
    for (int n = 0; n < 40 && timer_active !== 1'b1; n++) @(posedge pclk);
    repeat (10) @(posedge pclk);
    hcount(20, hi);
    chk(hi, 32'd8);
    apb(1'b1, 8'h00, 32'h0000_0044, 4'h3);
    for (int n = 0; n < 40 && timer_active !== 1'b0; n++) @(posedge pclk);
    chk({31'h0, timer_active}, 32'h0);
    // normal frequency: one toggle per five-edge period, so half the cycles are high
    apb(1'b1, 8'h00, 32'h0000_0006, 4'h3);
    for (int n = 0; n < 40 && timer_active !== 1'b1; n++) @(posedge pclk);
    repeat (10) @(posedge pclk);
    hcount(20, hi);
    chk(hi, 32'd10);
    conclude();
  end
endmodule // timer_control_a_logic_bench
